/* File: rtl/sew_array.sv */
// Word storage held in flip-flops with a page write port and a fill port
`timescale 1ns/1ps
module sew_array #(
  parameter int unsigned WORDS = sew_pkg::WORDS
) (
  input logic clk,
  input logic rst_n,
  input logic page_we,
  input logic fill_we,
  input logic [7:0] base_addr,
  input logic [3:0][15:0] page_data,
  input logic [3:0] page_mask,
  input logic [15:0] fill_data,
  input logic [7:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem_r [WORDS];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  for (genvar g = 0; g < WORDS; g++) begin : g_word
    localparam logic [7:0] A = 8'(g);
    // All words of a page land in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_r[g] <= sew_pkg::ERASED_WORD;
      end else if (fill_we) begin
        mem_r[g] <= fill_data;
      end else if (page_we && base_addr[7:2] == A[7:2] && page_mask[A[1:0]]) begin
        mem_r[g] <= page_data[A[1:0]];
      end
    end
  end

  assign rd_data = mem_r[rd_addr];
endmodule : sew_array

/* File: rtl/sew_pkg.sv */
// Shared constants and types of the serial word-access memory block
package sew_pkg;
  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORDS = 256;
  localparam int unsigned PAGE_WORDS = 4;
  localparam int unsigned PAGE_BITS = 2;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ----------------------------------------------------------------
  // Instruction framing
  // ----------------------------------------------------------------
  localparam logic [3:0] HDR_LAST = 4'h9;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam logic [3:0] PR_BITS = 4'h9;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PAGE = 2'h3;
  localparam logic [1:0] OP_MISC = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_WREN = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [7:0] PCLR_ADDR = 8'hFF;
  localparam logic [7:0] PFRZ_ADDR = 8'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PROT_ADDR_RST = 8'hFF;
  localparam logic PROT_FLAG_RST = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * CLK_KHZ;

  typedef enum logic [2:0] {S_IDLE, S_HDR, S_DATA, S_RD, S_PRD, S_DONE} sew_state_t;
  typedef enum logic [3:0] {
    C_NONE, C_READ, C_WRITE, C_PAGE_PROGRAM, C_FILL_ARRAY, C_WRITE_ENABLE,
    C_WRITE_LOCK, C_PROT_READ, C_PROT_WRITE, C_PROT_CLEAR, C_PROT_ARM, C_PROT_FREEZE
  } sew_cmd_t;
endpackage : sew_pkg

/* File: rtl/sew_word_access.sv */
// Instruction decoder, protection and busy timing of the serial word memory
//
// Functional notes
// - Storage is 256 words of 16 bits, 8-bit word address.
// - Read loads the given address into a pointer, then shifts that word out.
// - Pointer advances after each word; words keep coming while select stays high.
// - One read streams any number of 16-bit words without a break, the pointer wrapping from the top to address 0.
// - Page program takes up to 4 words and stores them in one cycle.
// - Fill array writes the one given word into every location.
// - Writes need the write-enable pin high; otherwise they are refused.
// - Protect register access needs the protect-access pin high.
// - Once the lock bit is set, protect address and flag never change.
// - Programming is self-timed with built-in erase; no separate erase step.
// - Single write stores all 16 bits into exactly one location.
// - Word or page write is dropped entirely if any target is protected.
// - After programming starts, select high shows busy/ready on the output.
// - Every word starts at all ones.
// - Programming lasts about 5 ms, reported busy throughout.
// - Instruction is start bit one, 2-bit opcode, 8-bit address.
// - Read outputs one zero dummy bit, then 16 bits MSB first, no gaps.
// - Output reads zero while busy and one when ready.
// - Writes start disabled; enable instruction sets, disable instruction clears, both only with pin high.
`timescale 1ns/1ps
module sew_word_access #(
  parameter int unsigned PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
  input logic clk,
  input logic rst_n,
  input logic cs,
  input logic sclk,
  input logic din,
  input logic wr_en_pin,
  input logic prot_en_pin,
  output logic dout,
  output logic dout_oe,
  output logic busy
);
  localparam int unsigned CNT_W = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // Reset release and pin sampling
  // ----------------------------------------------------------------
  logic [1:0] rs_r;
  logic rst_ni;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rs_r <= 2'h0;
    else rs_r <= {rs_r[0], 1'b1};
  end
  assign rst_ni = rs_r[1];

  // Order: cs, sclk, din, wr_en_pin, prot_en_pin
  logic [4:0] s1_r, s2_r;
  logic sclk_d_r, cs_d_r;
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b0;
    end else begin
      s1_r <= {cs, sclk, din, wr_en_pin, prot_en_pin};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[3];
      cs_d_r <= s2_r[4];
    end
  end

  logic cs_s, din_s, rise, cs_fall;
  assign cs_s = s2_r[4];
  assign din_s = s2_r[2];
  assign rise = cs_s & s2_r[3] & ~sclk_d_r;
  assign cs_fall = cs_d_r & ~cs_s;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic sew_pkg::sew_cmd_t sew_decode(input logic [9:0] h, input logic pre);
    sew_decode = sew_pkg::C_NONE;
    case (h[9:8])
      sew_pkg::OP_READ: sew_decode = pre ? sew_pkg::C_PROT_READ : sew_pkg::C_READ;
      sew_pkg::OP_WRITE: sew_decode = pre ? sew_pkg::C_PROT_WRITE : sew_pkg::C_WRITE;
      sew_pkg::OP_PAGE: begin
        if (!pre) sew_decode = sew_pkg::C_PAGE_PROGRAM;
        else if (h[7:0] == sew_pkg::PCLR_ADDR) sew_decode = sew_pkg::C_PROT_CLEAR;
      end
      default: begin
        if (h[7:6] == sew_pkg::EXT_WREN) begin
          sew_decode = pre ? sew_pkg::C_PROT_ARM : sew_pkg::C_WRITE_ENABLE;
        end else if (!pre && h[7:6] == sew_pkg::EXT_FILL) begin
          sew_decode = sew_pkg::C_FILL_ARRAY;
        end else if (!pre && h[7:6] == sew_pkg::EXT_LOCK) begin
          sew_decode = sew_pkg::C_WRITE_LOCK;
        end else if (pre && h[7:0] == sew_pkg::PFRZ_ADDR) begin
          sew_decode = sew_pkg::C_PROT_FREEZE;
        end
      end
    endcase
  endfunction : sew_decode

  function automatic logic is_prot(input logic [7:0] a, input logic [7:0] pa, input logic pf);
    is_prot = !pf && a >= pa;
  endfunction : is_prot

  // ----------------------------------------------------------------
  // Framing, data capture and serial output
  // ----------------------------------------------------------------
  sew_pkg::sew_state_t st_r;
  sew_pkg::sew_cmd_t cmd_r, dec_cmd;
  logic [3:0] hcnt_r, dcnt_r, rcnt_r;
  logic [9:0] hdr_r, hdr_nxt;
  logic [15:0] dshift_r, dshift_nxt, rshift_r, rd_data;
  logic [3:0][15:0] buf_r;
  logic [3:0] mask_r;
  logic [1:0] idx_r;
  logic [2:0] words_r;
  logic [7:0] ptr_r, prot_addr_r;
  logic bad_r, w_ok_r, pre_ok_r, dout_r, prot_flag_r, busy_r;

  assign hdr_nxt = {hdr_r[8:0], din_s};
  assign dshift_nxt = {dshift_r[14:0], din_s};
  assign dec_cmd = sew_decode(hdr_nxt, s2_r[0]);

  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      st_r <= sew_pkg::S_IDLE;
      cmd_r <= sew_pkg::C_NONE;
      hcnt_r <= 4'h0;
      dcnt_r <= 4'h0;
      rcnt_r <= 4'h0;
      hdr_r <= 10'h000;
      dshift_r <= 16'h0000;
      rshift_r <= 16'h0000;
      buf_r <= '0;
      mask_r <= 4'h0;
      idx_r <= 2'h0;
      words_r <= 3'h0;
      ptr_r <= 8'h00;
      bad_r <= 1'b0;
      w_ok_r <= 1'b0;
      pre_ok_r <= 1'b0;
      dout_r <= 1'b1;
    end else if (!cs_s) begin
      st_r <= sew_pkg::S_IDLE;
      // Forget the instruction once select drops, so a bare select pulse cannot commit it again
      cmd_r <= sew_pkg::C_NONE;
    end else if (st_r == sew_pkg::S_IDLE) begin
      dout_r <= ~busy_r;
      // A start bit during programming is ignored
      if (rise && din_s && !busy_r) begin
        st_r <= sew_pkg::S_HDR;
        hcnt_r <= 4'h0;
        cmd_r <= sew_pkg::C_NONE;
        w_ok_r <= s2_r[1];
        pre_ok_r <= s2_r[0];
        words_r <= 3'h0;
        mask_r <= 4'h0;
        bad_r <= 1'b0;
      end
    end else if (rise) begin
      // Side-band enables must hold over the whole instruction
      w_ok_r <= w_ok_r & s2_r[1];
      pre_ok_r <= pre_ok_r & s2_r[0];
      case (st_r)
        sew_pkg::S_HDR: begin
          hdr_r <= hdr_nxt;
          hcnt_r <= hcnt_r + 4'h1;
          if (hcnt_r == sew_pkg::HDR_LAST) begin
            cmd_r <= dec_cmd;
            idx_r <= hdr_nxt[1:0];
            ptr_r <= hdr_nxt[7:0];
            dcnt_r <= 4'h0;
            rcnt_r <= 4'h0;
            case (dec_cmd)
              sew_pkg::C_READ: begin
                st_r <= sew_pkg::S_RD;
                dout_r <= 1'b0;
              end
              sew_pkg::C_PROT_READ: begin
                st_r <= sew_pkg::S_PRD;
                dout_r <= 1'b0;
                rshift_r <= {prot_addr_r, prot_flag_r, 7'h00};
              end
              sew_pkg::C_WRITE, sew_pkg::C_PAGE_PROGRAM, sew_pkg::C_FILL_ARRAY: begin
                st_r <= sew_pkg::S_DATA;
              end
              default: st_r <= sew_pkg::S_DONE;
            endcase
          end
        end
        sew_pkg::S_DATA: begin
          dshift_r <= dshift_nxt;
          dcnt_r <= dcnt_r + 4'h1;
          if (dcnt_r == sew_pkg::DATA_LAST) begin
            buf_r[idx_r] <= dshift_nxt;
            mask_r[idx_r] <= 1'b1;
            // Only the low two address bits move inside a page
            idx_r <= idx_r + 2'h1;
            bad_r <= bad_r | is_prot({hdr_r[7:2], idx_r}, prot_addr_r, prot_flag_r);
            words_r <= words_r + 3'h1;
            if (cmd_r != sew_pkg::C_PAGE_PROGRAM || words_r == 3'(sew_pkg::PAGE_WORDS - 1)) begin
              st_r <= sew_pkg::S_DONE;
            end
          end
        end
        sew_pkg::S_RD: begin
          rcnt_r <= rcnt_r + 4'h1;
          if (rcnt_r == 4'h0) begin
            // No dummy bit between words; the pointer wraps at the top
            dout_r <= rd_data[15];
            rshift_r <= {rd_data[14:0], 1'b0};
            ptr_r <= ptr_r + 8'h01;
          end else begin
            dout_r <= rshift_r[15];
            rshift_r <= {rshift_r[14:0], 1'b0};
          end
        end
        sew_pkg::S_PRD: begin
          if (rcnt_r != sew_pkg::PR_BITS) begin
            rcnt_r <= rcnt_r + 4'h1;
            dout_r <= rshift_r[15];
            rshift_r <= {rshift_r[14:0], 1'b0};
          end
        end
        sew_pkg::S_DONE: begin
          // Clocking past the last bit voids the instruction
          cmd_r <= sew_pkg::C_NONE;
        end
        default: st_r <= sew_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) dout_oe <= 1'b0;
    else dout_oe <= cs_s;
  end
  assign dout = dout_r;

  // ----------------------------------------------------------------
  // Commit on select falling: write enable, protect register
  // ----------------------------------------------------------------
  logic wen_r, pren_r, otp_r, wr_ok, pr_ok, page_we, fill_we, pr_we, prog_go;
  assign wr_ok = w_ok_r & wen_r;
  assign pr_ok = wr_ok & pre_ok_r & pren_r & ~otp_r;
  assign page_we = cs_fall & wr_ok & ~bad_r &
    ((cmd_r == sew_pkg::C_WRITE && words_r == 3'h1) ||
     (cmd_r == sew_pkg::C_PAGE_PROGRAM && words_r != 3'h0));
  assign fill_we = cs_fall & wr_ok & prot_flag_r &
    cmd_r == sew_pkg::C_FILL_ARRAY & words_r == 3'h1;
  assign pr_we = cs_fall & pr_ok & (cmd_r == sew_pkg::C_PROT_WRITE ||
    cmd_r == sew_pkg::C_PROT_CLEAR || cmd_r == sew_pkg::C_PROT_FREEZE);
  assign prog_go = page_we | fill_we | pr_we;

  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      wen_r <= 1'b0;
      pren_r <= 1'b0;
      otp_r <= 1'b0;
      prot_addr_r <= sew_pkg::PROT_ADDR_RST;
      prot_flag_r <= sew_pkg::PROT_FLAG_RST;
    end else if (cs_fall && cmd_r != sew_pkg::C_NONE) begin
      // Arming lasts for the very next instruction only
      pren_r <= cmd_r == sew_pkg::C_PROT_ARM && wr_ok && pre_ok_r;
      case (cmd_r)
        sew_pkg::C_WRITE_ENABLE: if (w_ok_r) wen_r <= 1'b1;
        sew_pkg::C_WRITE_LOCK: if (w_ok_r) wen_r <= 1'b0;
        sew_pkg::C_PROT_WRITE: begin
          if (pr_ok) begin
            prot_addr_r <= hdr_r[7:0];
            prot_flag_r <= 1'b0;
          end
        end
        sew_pkg::C_PROT_CLEAR: begin
          if (pr_ok) begin
            prot_addr_r <= sew_pkg::PCLR_ADDR;
            prot_flag_r <= 1'b1;
          end
        end
        sew_pkg::C_PROT_FREEZE: if (pr_ok) otp_r <= 1'b1;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Self-timed programming cycle
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] prog_cnt_r;
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
    end else if (prog_go) begin
      busy_r <= 1'b1;
      prog_cnt_r <= CNT_W'(PROG_CYCLES - 1);
    end else if (busy_r) begin
      if (prog_cnt_r == '0) busy_r <= 1'b0;
      else prog_cnt_r <= prog_cnt_r - 1'b1;
    end
  end
  assign busy = busy_r;

  sew_array sew_array_inst (
    .clk(clk),
    .rst_n(rst_ni),
    .page_we(page_we),
    .fill_we(fill_we),
    .base_addr(hdr_r[7:0]),
    .page_data(buf_r),
    .page_mask(mask_r),
    .fill_data(dshift_r),
    .rd_addr(ptr_r),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_ni);

  a_prog_len: assert property ($rose(busy_r) |-> prog_cnt_r == CNT_W'(PROG_CYCLES - 1))
    else $error("programming count not loaded");
  a_prog_end: assert property (busy_r && prog_cnt_r == '0 |=> !busy_r)
    else $error("busy did not end");
  a_prog_start: assert property (page_we || fill_we |=> busy_r)
    else $error("write without busy");
  a_busy_out: assert property (busy_r && cs_s |=> !dout_r)
    else $error("busy not shown on output");
  a_wr_gate: assert property (page_we || fill_we |-> wen_r && w_ok_r)
    else $error("write without enable");
  a_wen_rise: assert property ($rose(wen_r) |->
    $past(cs_fall) && $past(cmd_r) == sew_pkg::C_WRITE_ENABLE)
    else $error("write enable set without instruction");
  a_otp_lock: assert property (otp_r |=> $stable(prot_addr_r) && $stable(prot_flag_r))
    else $error("protect register changed after lock");
  a_prot_gate: assert property ($changed(prot_flag_r) |-> $past(pre_ok_r) && $past(pren_r))
    else $error("protect change without access");
  a_prot_block: assert property (page_we |-> !bad_r)
    else $error("write into protected area");
  a_fill_open: assert property (fill_we |-> prot_flag_r)
    else $error("fill while protected");
  a_one_word: assert property (page_we && cmd_r == sew_pkg::C_WRITE |-> $onehot(mask_r))
    else $error("single write touches several words");
  a_page_max: assert property (words_r <= 3'(sew_pkg::PAGE_WORDS))
    else $error("page holds too many words");
  a_read_start: assert property (rise && st_r == sew_pkg::S_HDR && hcnt_r == sew_pkg::HDR_LAST &&
    dec_cmd == sew_pkg::C_READ |=> !dout_r && ptr_r == hdr_r[7:0])
    else $error("read did not start with dummy zero");
  a_ptr_inc: assert property (rise && st_r == sew_pkg::S_RD && rcnt_r == 4'h0 |=>
    ptr_r == $past(ptr_r) + 8'h01)
    else $error("read pointer did not advance");

  c_read_wrap: cover property (st_r == sew_pkg::S_RD && ptr_r == 8'hFF ##[1:200] ptr_r == 8'h00);
  c_page_four: cover property (page_we && mask_r == 4'hF);
  c_fill: cover property (fill_we);
  c_prot_write: cover property (pr_we && cmd_r == sew_pkg::C_PROT_WRITE);
endmodule : sew_word_access

/* File: verification/sew_host_model.sv */
// Host-side serial master model that drives the word memory link pins
`timescale 1ns/1ps
module sew_host_model (
  input wire logic clk,
  input wire logic dout,
  input wire logic dout_oe,
  output logic cs,
  output logic sclk,
  output logic din,
  output logic wr_en_pin,
  output logic prot_en_pin
);
  // ------------------------------------------------------------
  // Link timing: 160 ns link clock from the 10 ns system clock
  // ------------------------------------------------------------
  localparam int HALF = 8;
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
    din = 1'b0;
    wr_en_pin = 1'b0;
    prot_en_pin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pins(input logic w, input logic p);
    tick(1);
    wr_en_pin = w;
    prot_en_pin = p;
  endtask : pins
  task automatic open_frame();
    tick(1);
    cs = 1'b1;
    tick(4);
  endtask : open_frame
  // Link clock idles low; din flips so a stale level never passes for data
  task automatic close_frame();
    cs = 1'b0;
    din = ~din;
    tick(26);
  endtask : close_frame
  // Select high without clocks: the device shows its busy/ready state
  task automatic peek(output logic v, output logic oe);
    open_frame();
    v = dout;
    oe = dout_oe;
    close_frame();
  endtask : peek
  // Bits go MSB first; q collects the output late in each low phase
  task automatic frame(input logic [127:0] b, input int n, output logic [127:0] q);
    open_frame();
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      din = b[i];
      tick(2);
      sclk = 1'b1;
      tick(HALF);
      sclk = 1'b0;
      tick(HALF - 2);
      q = {q[126:0], dout};
    end
    close_frame();
  endtask : frame
endmodule : sew_host_model

/* File: verification/sew_word_access_tb.sv */
// Self-checking bench of the serial word memory against a behavioural model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); \
  end \
end
module sew_word_access_tb;
  // ------------------------------------------------------------
  // Pins, model state and instances
  // ------------------------------------------------------------
  localparam int PROG = 200;
  logic clk, rst_n, cs, sclk, din, wr_en_pin, prot_en_pin, dout, dout_oe, busy;
  logic v, oe, pflag;
  int errors, checks, seed, hi_cnt;
  logic [15:0] mem [256];
  logic [15:0] d;
  logic [7:0] a, paddr;
  logic [127:0] q, b, en_b;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end
  end

  sew_host_model sew_host_model_inst (.clk(clk), .dout(dout), .dout_oe(dout_oe), .cs(cs),
    .sclk(sclk), .din(din), .wr_en_pin(wr_en_pin), .prot_en_pin(prot_en_pin));
  sew_word_access #(.PROG_CYCLES(PROG)) sew_word_access_inst (.clk(clk), .rst_n(rst_n),
    .cs(cs), .sclk(sclk), .din(din), .wr_en_pin(wr_en_pin), .prot_en_pin(prot_en_pin),
    .dout(dout), .dout_oe(dout_oe), .busy(busy));

  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  function automatic logic [127:0] hd(input logic [1:0] op, input logic [7:0] ad);
    return {117'h0, 1'b1, op, ad};
  endfunction : hd

  // Any instruction; ex says whether a programming cycle must follow
  task automatic cmd(input logic [127:0] bits, input int n, input logic ex);
    hi_cnt = 0;
    sew_host_model_inst.frame(bits, n, q);
    if (ex) begin
      sew_host_model_inst.peek(v, oe);
      `CHK("busy on dout", 1'b0, v)
      `CHK("dout_oe", 1'b1, oe)
      for (int i = 0; i < 40 && busy === 1'b1; i++) begin
        sew_host_model_inst.tick(10);
      end
      sew_host_model_inst.peek(v, oe);
      `CHK("ready on dout", 1'b1, v)
    end
    `CHK("program cycles", ex ? PROG : 0, hi_cnt)
  endtask : cmd

  task automatic wr(input logic [1:0] op, input logic [7:0] ad, input logic [15:0] dv,
                    input logic ex);
    cmd((hd(op, ad) << 16) | 128'(dv), 27, ex);
    if (ex && op == sew_pkg::OP_WRITE) begin
      mem[ad] = dv;
    end
  endtask : wr

  task automatic rd(input logic [7:0] ad, input int nw);
    sew_host_model_inst.frame(hd(sew_pkg::OP_READ, ad) << (16 * nw), 11 + 16 * nw, q);
    `CHK("dummy bit", 1'b0, q[16 * nw])
    for (int i = 0; i < nw; i++) begin
      `CHK("read word", mem[8'(ad + i)], q[16 * (nw - 1 - i) +: 16])
    end
  endtask : rd

  task automatic prd();
    sew_host_model_inst.frame(hd(sew_pkg::OP_READ, 8'h00) << 9, 20, q);
    `CHK("protect read", {1'b0, paddr, pflag}, q[9:0])
  endtask : prd

  initial begin
    seed = 71;
    errors = 0;
    checks = 0;
    hi_cnt = 0;
    rst_n = 1'b0;
    paddr = 8'hFF;
    pflag = 1'b1;
    en_b = hd(sew_pkg::OP_MISC, {sew_pkg::EXT_WREN, 6'h00});
    foreach (mem[i]) mem[i] = 16'hFFFF;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    a = 8'($random(seed));
    d = 16'($random(seed));
    rd(a, 1);
    sew_host_model_inst.pins(1'b1, 1'b0);
    wr(sew_pkg::OP_WRITE, a, d, 1'b0);
    cmd(en_b, 11, 1'b0);
    sew_host_model_inst.pins(1'b0, 1'b0);
    wr(sew_pkg::OP_WRITE, a, d, 1'b0);
    sew_host_model_inst.pins(1'b1, 1'b0);
    wr(sew_pkg::OP_WRITE, a, d, 1'b1);
    rd(a - 8'h01, 3);
    // Pages start at word 2 of the page so the word index wraps inside the page for three and four words
    for (int k = 1; k <= 4; k++) begin
      a = (8'($random(seed)) & 8'hFC) | 8'h02;
      b = hd(sew_pkg::OP_PAGE, a);
      for (int i = 0; i < k; i++) begin
        d = 16'($random(seed));
        b = (b << 16) | 128'(d);
        mem[{a[7:2], 2'(a[1:0] + i)}] = d;
      end
      cmd(b, 11 + 16 * k, 1'b1);
      rd(a & 8'hFC, 4);
    end
    sew_host_model_inst.pins(1'b1, 1'b1);
    cmd(en_b, 11, 1'b0);
    cmd(hd(sew_pkg::OP_WRITE, 8'h80), 11, 1'b1);
    paddr = 8'h80;
    pflag = 1'b0;
    prd();
    sew_host_model_inst.pins(1'b1, 1'b0);
    wr(sew_pkg::OP_WRITE, 8'h80, 16'h1234, 1'b0);
    wr(sew_pkg::OP_WRITE, 8'h7F, 16'h1234, 1'b1);
    cmd((hd(sew_pkg::OP_PAGE, 8'hC1) << 32) | 128'h5555_AAAA, 43, 1'b0);
    wr(sew_pkg::OP_MISC, 8'h40, 16'h0F0F, 1'b0);
    rd(8'h7F, 3);
    sew_host_model_inst.pins(1'b1, 1'b1);
    cmd(en_b, 11, 1'b0);
    cmd(hd(sew_pkg::OP_PAGE, sew_pkg::PCLR_ADDR), 11, 1'b1);
    paddr = 8'hFF;
    pflag = 1'b1;
    prd();
    sew_host_model_inst.pins(1'b1, 1'b0);
    d = 16'($random(seed));
    wr(sew_pkg::OP_MISC, 8'h40, d, 1'b1);
    foreach (mem[i]) mem[i] = d;
    // A distinct word at the bottom makes the pointer wrap visible
    wr(sew_pkg::OP_WRITE, 8'h00, ~d, 1'b1);
    rd(8'hFE, 7);
    // With the access pin low the arm code is only a write enable
    cmd(en_b, 11, 1'b0);
    sew_host_model_inst.pins(1'b1, 1'b1);
    cmd(hd(sew_pkg::OP_WRITE, 8'h20), 11, 1'b0);
    cmd(en_b, 11, 1'b0);
    cmd(hd(sew_pkg::OP_MISC, sew_pkg::PFRZ_ADDR), 11, 1'b1);
    cmd(en_b, 11, 1'b0);
    cmd(hd(sew_pkg::OP_WRITE, 8'h10), 11, 1'b0);
    cmd(en_b, 11, 1'b0);
    cmd(hd(sew_pkg::OP_PAGE, sew_pkg::PCLR_ADDR), 11, 1'b0);
    prd();
    sew_host_model_inst.pins(1'b1, 1'b0);
    cmd(hd(sew_pkg::OP_MISC, {sew_pkg::EXT_LOCK, 6'h00}), 11, 1'b0);
    wr(sew_pkg::OP_WRITE, 8'h33, 16'hABCD, 1'b0);
    rd(8'h33, 1);
    conclude();
  end

  // Hang guard, far beyond the few tens of thousands of cycles the run needs
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : sew_word_access_tb
